//--- verilog/sop_pkg.sv
// Constants for the serial link out-of-band and power state block
package sop_pkg;
   // Clock period and out-of-band spacing times
   localparam int unsigned CLK_PS = 8000;
   localparam int unsigned FIRST_SPACING_PS = 106700;
   localparam int unsigned SECOND_SPACING_PS = 320000;
   localparam int unsigned FIRST_SPACING_CYC =
      (FIRST_SPACING_PS + CLK_PS - 1) / CLK_PS;
   localparam int unsigned SECOND_SPACING_CYC =
      (SECOND_SPACING_PS + CLK_PS - 1) / CLK_PS;
   // Longest exit latencies, rounded down to whole cycles
   localparam int unsigned PARTIAL_EXIT_NS = 10000;
   localparam int unsigned SLUMBER_EXIT_US = 10000;
   localparam int unsigned PARTIAL_EXIT_CYC =
      PARTIAL_EXIT_NS * 1000 / CLK_PS;
   localparam int unsigned SLUMBER_EXIT_CYC =
      SLUMBER_EXIT_US * 1000 / (CLK_PS / 1000);
   localparam int unsigned TMR_W = 21;
   // Burst counts and receive classification
   localparam int unsigned TX_BURSTS = 6;
   localparam int unsigned RX_GAPS = 3;
   localparam logic [7:0] WAKE_GAP_MAX =
      8'((FIRST_SPACING_CYC + SECOND_SPACING_CYC) / 2);
   localparam logic [7:0] RX_GAP_LIMIT = 8'(2 * SECOND_SPACING_CYC);
   // Identify data
   localparam logic [7:0] ID_W_SERIAL0 = 8'h0a;
   localparam logic [7:0] ID_W_SERIAL9 = 8'h13;
   localparam logic [7:0] ID_W_MULT_MAX = 8'h2f;
   localparam logic [7:0] ID_W_MULT_CUR = 8'h3b;
   localparam logic [7:0] ID_W_CYC_FIRST = 8'h41;
   localparam logic [7:0] ID_W_CYC_LAST = 8'h44;
   localparam logic [15:0] ID_MULT_MAX = 16'h8008;
   localparam logic [15:0] ID_MULT_CUR = 16'h0108;
   localparam logic [15:0] ID_CYC_TIME = 16'h0078;
   localparam int unsigned SERIAL_CHARS = 20;
   // Link power and out-of-band states
   typedef enum logic [3:0] {
      ST_AWAIT_RESET, ST_TX_INIT, ST_AWAIT_WAKE, ST_TX_WAKE, ST_ALIGN,
      ST_READY, ST_PARTIAL, ST_SLUMBER, ST_DEV_WAKE
   } sop_state_t;
endpackage

//--- verilog/sop_link_power.sv
// Device-side out-of-band signalling, power states and identify words
//
// Summary of operation
// R1 - Send and detect COMRESET, COMINIT, COMWAKE only
// R2 - Each burst followed by timed common-mode idle
// R3 - COMWAKE returns link from Partial or Slumber
// R4 - Ready means PLL running, link synchronized
// R5 - Partial: common-mode lines, exit within 10 us
// R6 - Slumber: reduced power, exit within 10 ms
// R7 - Host wake enters sequence at host wake
// R8 - Device wake enters sequence at device wake
// R9 - Resume skips calibration, keeps power-on rate
// R10 - Slumber entry uses same handshake as Partial
// R11 - Identify word 47 reads 8008h
// R12 - Identify word 59 reads 0108h
// R13 - Identify words 65 to 68 read 0078h
// R14 - Identify words 10 to 19 hold serial
// R15 - Unplanned drop from ready is signal loss
// R16 - No frames or data while powered down
`timescale 1ns/100ps
module sop_link_power
   import sop_pkg::*;
#(
   parameter int unsigned BURST_CYC = FIRST_SPACING_CYC,
   parameter int unsigned SLUMBER_CYC = SLUMBER_EXIT_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rx_burst,
   input wire logic rx_align_seen,
   input wire logic [1:0] spd_negotiated,
   input wire logic pm_partial_go,
   input wire logic pm_slumber_go,
   input wire logic dev_wake_req,
   input wire logic [7:0] id_addr,
   input wire logic [8*SERIAL_CHARS-1:0] serial_num,
   output logic tx_burst_reg,
   output logic tx_common_mode_reg,
   output logic tx_align_reg,
   output logic [1:0] align_rate_reg,
   output logic phy_ready_reg,
   output logic pll_on_reg,
   output logic in_partial_reg,
   output logic in_slumber_reg,
   output logic link_accept_reg,
   output logic loss_reg,
   output logic [15:0] id_data_reg
);
   sop_state_t state_reg, state_next;
   logic rx_s1_reg, rx_s2_reg, rx_d_reg;
   logic [7:0] gap_reg;
   logic [1:0] gap_n_reg;
   logic gap_wake_reg;
   logic det_reset, det_wake, rx_rise, gap_is_wake, gap_same;
   logic tx_state, tx_wake_kind, tx_gap_reg, tx_done;
   logic [7:0] tx_cnt_reg, tx_lim;
   logic [2:0] tx_num_reg;
   logic cal_done_reg, resume_reg, slumber_reg, tmr_exp;
   logic [TMR_W-1:0] tmr_reg;
   logic in_low_pwr, low_next;
   // Receive line passes two flip-flops before any use
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_s1_reg <= 1'b0;
         rx_s2_reg <= 1'b0;
         rx_d_reg <= 1'b0;
      end else begin
         rx_s1_reg <= rx_burst;
         rx_s2_reg <= rx_s1_reg;
         rx_d_reg <= rx_s2_reg;
      end
   end
   // Classify each idle gap by length: short is wake, long is reset
   assign rx_rise = rx_s2_reg & ~rx_d_reg;
   assign gap_is_wake = (gap_reg <= WAKE_GAP_MAX); // R1
   assign gap_same = (gap_n_reg == 2'd0) || (gap_is_wake == gap_wake_reg);
   assign det_wake = rx_rise && gap_reg <= RX_GAP_LIMIT && gap_same &&
      gap_n_reg == 2'(RX_GAPS - 1) && gap_is_wake;
   assign det_reset = rx_rise && gap_reg <= RX_GAP_LIMIT && gap_same &&
      gap_n_reg == 2'(RX_GAPS - 1) && !gap_is_wake;
   // Idle length counter and matching gap counter
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_reg <= 8'hff;
         gap_n_reg <= 2'd0;
         gap_wake_reg <= 1'b0;
      end else begin
         if (rx_s2_reg)
            gap_reg <= 8'h00;
         else if (gap_reg != 8'hff)
            gap_reg <= gap_reg + 8'h01;
         if (rx_rise) begin
            gap_wake_reg <= gap_is_wake;
            if (gap_reg > RX_GAP_LIMIT || det_wake || det_reset)
               gap_n_reg <= 2'd0;
            else if (!gap_same)
               gap_n_reg <= 2'd1;
            else
               gap_n_reg <= gap_n_reg + 2'd1;
         end
      end
   end
   // Transmit burst engine: burst, then idle of the kind's spacing
   assign tx_state = state_reg == ST_TX_INIT || state_reg == ST_TX_WAKE ||
      state_reg == ST_DEV_WAKE;
   assign tx_wake_kind = state_reg != ST_TX_INIT;
   assign tx_lim = !tx_gap_reg ? 8'(BURST_CYC) :
      tx_wake_kind ? 8'(FIRST_SPACING_CYC) : 8'(SECOND_SPACING_CYC); // R2
   assign tx_done = tx_state && tx_gap_reg && tx_cnt_reg == tx_lim - 8'h01
      && tx_num_reg == 3'(TX_BURSTS - 1);

   always_ff @(posedge clk) begin
      if (rst || !tx_state || tx_done) begin
         tx_cnt_reg <= 8'h00;
         tx_gap_reg <= 1'b0;
         tx_num_reg <= 3'd0;
      end else if (tx_cnt_reg == tx_lim - 8'h01) begin
         tx_cnt_reg <= 8'h00;
         tx_gap_reg <= ~tx_gap_reg;
         if (tx_gap_reg)
            tx_num_reg <= tx_num_reg + 3'd1;
      end else begin
         tx_cnt_reg <= tx_cnt_reg + 8'h01;
      end
   end
   // Resume watchdog against the exit latency of the left state
   assign tmr_exp = resume_reg &&
      tmr_reg >= (slumber_reg ? TMR_W'(SLUMBER_CYC) :
      TMR_W'(PARTIAL_EXIT_CYC)); // R5 R6
   assign in_low_pwr = state_reg == ST_PARTIAL || state_reg == ST_SLUMBER;
   // Power and out-of-band sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_AWAIT_RESET: ;
         ST_TX_INIT:
            if (tx_done)
               state_next = ST_AWAIT_WAKE;
         ST_AWAIT_WAKE:
            if (det_wake)
               state_next = ST_TX_WAKE;
         ST_TX_WAKE:
            if (tx_done)
               state_next = ST_ALIGN;
         ST_ALIGN:
            if (rx_align_seen)
               state_next = ST_READY;
         ST_READY:
            if (pm_partial_go)
               state_next = ST_PARTIAL;
            else if (pm_slumber_go)
               state_next = ST_SLUMBER; // R10
         ST_PARTIAL, ST_SLUMBER:
            if (det_wake)
               state_next = ST_TX_WAKE; // R3 R7
            else if (dev_wake_req)
               state_next = ST_DEV_WAKE; // R8
         ST_DEV_WAKE:
            if (tx_done)
               state_next = ST_AWAIT_WAKE;
         default:
            state_next = ST_AWAIT_RESET;
      endcase
      if (det_reset)
         state_next = ST_TX_INIT; // R1
      else if (tmr_exp)
         state_next = ST_AWAIT_RESET;
   end
   assign low_next = state_next == ST_PARTIAL || state_next == ST_SLUMBER;
   // State, resume timing and negotiated rate
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_AWAIT_RESET;
         resume_reg <= 1'b0;
         slumber_reg <= 1'b0;
         tmr_reg <= '0;
         cal_done_reg <= 1'b0;
         align_rate_reg <= 2'd0;
      end else begin
         state_reg <= state_next;
         // A reset train cancels any resume in progress
         if (state_next == ST_READY || tmr_exp || det_reset) begin
            resume_reg <= 1'b0;
         end else if (in_low_pwr && !low_next) begin
            resume_reg <= 1'b1;
            slumber_reg <= state_reg == ST_SLUMBER;
         end
         tmr_reg <= resume_reg ? tmr_reg + TMR_W'(1) : '0;
         if (det_reset)
            cal_done_reg <= 1'b0;
         else if (state_next == ST_READY)
            cal_done_reg <= 1'b1;
         if (state_reg == ST_ALIGN && !cal_done_reg)
            align_rate_reg <= spd_negotiated; // R9
      end
   end
   // Line and status outputs, all from flip-flops
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_burst_reg <= 1'b0;
         tx_common_mode_reg <= 1'b1;
         tx_align_reg <= 1'b0;
         phy_ready_reg <= 1'b0;
         pll_on_reg <= 1'b1;
         in_partial_reg <= 1'b0;
         in_slumber_reg <= 1'b0;
         link_accept_reg <= 1'b0;
         loss_reg <= 1'b0;
      end else begin
         tx_burst_reg <= tx_state && !tx_gap_reg && !tx_done;
         tx_common_mode_reg <= !(tx_state && !tx_gap_reg && !tx_done) &&
            state_reg != ST_ALIGN && state_reg != ST_READY; // R2 R5
         tx_align_reg <= state_next == ST_ALIGN;
         phy_ready_reg <= state_next == ST_READY; // R4
         pll_on_reg <= state_next != ST_SLUMBER; // R4 R6
         in_partial_reg <= state_next == ST_PARTIAL;
         in_slumber_reg <= state_next == ST_SLUMBER;
         link_accept_reg <= state_next == ST_READY; // R16
         loss_reg <= state_reg == ST_READY && state_next != ST_READY &&
            !low_next; // R15
      end
   end
   // Identify word lookup
   function automatic logic [15:0] id_word(input logic [7:0] a,
      input logic [8*SERIAL_CHARS-1:0] sn);
      logic [7:0] k;
      k = a - ID_W_SERIAL0;
      id_word = 16'h0000;
      if (a >= ID_W_SERIAL0 && a <= ID_W_SERIAL9)
         id_word = sn[8*SERIAL_CHARS-1-16*k -: 16]; // R14
      else if (a == ID_W_MULT_MAX)
         id_word = ID_MULT_MAX; // R11
      else if (a == ID_W_MULT_CUR)
         id_word = ID_MULT_CUR; // R12
      else if (a >= ID_W_CYC_FIRST && a <= ID_W_CYC_LAST)
         id_word = ID_CYC_TIME; // R13
   endfunction
   // Identify read port, one cycle latency
   always_ff @(posedge clk) begin
      if (rst)
         id_data_reg <= 16'h0000;
      else
         id_data_reg <= id_word(id_addr, serial_num);
   end
   // Checks
   a_reset_detect: assert property (@(posedge clk) disable iff (rst) // R1
      det_reset |=> state_reg == ST_TX_INIT && !phy_ready_reg)
      else $error("Reset burst train not answered");
   a_burst_spacing: assert property (@(posedge clk) disable iff (rst) // R2
      $fell(tx_burst_reg) |-> !tx_burst_reg [*8])
      else $error("Idle after burst too short");
   a_host_wake: assert property (@(posedge clk) disable iff (rst) // R3
      (in_low_pwr && det_wake) |=> state_reg == ST_TX_WAKE)
      else $error("Wake from low power missed");
   a_ready_pll: assert property (@(posedge clk) disable iff (rst) // R4
      phy_ready_reg |-> pll_on_reg && !tx_common_mode_reg)
      else $error("Ready without active phy");
   a_partial_exit: assert property (@(posedge clk) disable iff (rst) // R5
      (resume_reg && !slumber_reg) |-> tmr_reg <= TMR_W'(PARTIAL_EXIT_CYC))
      else $error("Partial exit latency exceeded");
   a_slumber_exit: assert property (@(posedge clk) disable iff (rst) // R6
      (resume_reg && slumber_reg) |-> tmr_reg <= TMR_W'(SLUMBER_CYC))
      else $error("Slumber exit latency exceeded");
   a_dev_wake: assert property (@(posedge clk) disable iff (rst) // R8
      (in_low_pwr && dev_wake_req && !det_wake && !det_reset)
      |=> state_reg == ST_DEV_WAKE ##1 tx_burst_reg)
      else $error("Device wake did not start bursts");
   a_rate_kept: assert property (@(posedge clk) disable iff (rst) // R9
      (state_reg == ST_ALIGN && cal_done_reg) |=> $stable(align_rate_reg))
      else $error("Rate renegotiated on resume");
   a_slumber_entry: assert property (@(posedge clk) disable iff (rst) // R10
      (state_reg == ST_READY && pm_slumber_go && !pm_partial_go &&
      !det_reset) |=> in_slumber_reg && !pll_on_reg)
      else $error("Slumber entry missed");
   a_id_fixed: assert property (@(posedge clk) disable iff (rst) // R11
      (id_addr == ID_W_MULT_MAX) |=> id_data_reg == ID_MULT_MAX)
      else $error("Multiple sector limit word wrong");
   a_id_current: assert property (@(posedge clk) disable iff (rst) // R12
      (id_addr == ID_W_MULT_CUR) |=> id_data_reg == ID_MULT_CUR)
      else $error("Multiple sector setting word wrong");
   a_id_cycle: assert property (@(posedge clk) disable iff (rst) // R13
      (id_addr >= ID_W_CYC_FIRST && id_addr <= ID_W_CYC_LAST)
      |=> id_data_reg == ID_CYC_TIME)
      else $error("Cycle time word wrong");
   a_id_serial: assert property (@(posedge clk) disable iff (rst) // R14
      (id_addr == ID_W_SERIAL0) |=> id_data_reg == $past(serial_num[159:144]))
      else $error("Serial number word wrong");
   a_loss_flag: assert property (@(posedge clk) disable iff (rst) // R15
      ($fell(phy_ready_reg) && !in_partial_reg && !in_slumber_reg)
      |-> loss_reg)
      else $error("Signal loss not flagged");
   a_no_frames: assert property (@(posedge clk) disable iff (rst) // R16
      (in_partial_reg || in_slumber_reg) |-> !link_accept_reg)
      else $error("Link accepts data while powered down");

endmodule

//--- dv/sop_host_model.sv
// Host-side model: sends out-of-band bursts and answers ALIGN
`timescale 1ns/100ps
module sop_host_model
   import sop_pkg::*;
(
   input wire logic clk,
   input wire logic send_reset,
   input wire logic send_wake,
   input wire logic tx_align_reg,
   output logic rx_burst,
   output logic rx_align_seen
);
   int gap;
   logic [3:0] align_dly;
   initial begin
      rx_burst = 1'b0;
      rx_align_seen = 1'b0;
      align_dly = 4'h0;
   end
   // Four bursts with reset or wake spacing, lines idle in between
   always @(posedge clk) begin
      if (send_reset || send_wake) begin
         gap = send_reset ? SECOND_SPACING_CYC : FIRST_SPACING_CYC;
         repeat (4) begin
            rx_burst <= 1'b1;
            repeat (14) @(posedge clk);
            rx_burst <= 1'b0;
            repeat (gap) @(posedge clk);
         end
      end
   end
   // ALIGN is answered a few cycles after the device starts sending it
   always @(posedge clk) begin
      align_dly <= {align_dly[2:0], tx_align_reg};
      rx_align_seen <= align_dly[3];
   end
endmodule

//--- dv/serial_link_oob_power_states_tb.sv
// Self-checking testbench for the link power and out-of-band block
`timescale 1ns/100ps
module serial_link_oob_power_states_tb
   import sop_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic send_reset = 1'b0;
   logic send_wake = 1'b0;
   logic rx_burst, rx_align_seen, tx_burst_reg, tx_common_mode_reg;
   logic tx_align_reg, phy_ready_reg, pll_on_reg, in_partial_reg;
   logic in_slumber_reg, link_accept_reg, loss_reg;
   logic [1:0] spd_negotiated = 2'h2;
   logic [1:0] align_rate_reg;
   logic pm_partial_go = 1'b0;
   logic pm_slumber_go = 1'b0;
   logic dev_wake_req = 1'b0;
   logic [7:0] id_addr = 8'h00;
   logic [159:0] serial_num = "ABCDEFGHIJKLMNOPQRST";
   logic [15:0] id_data_reg;
   int bad_count = 0;
   int checks = 0;
   int loss_cnt = 0;
   int align_cnt = 0;

   always #4 clk = ~clk;

   sop_link_power #(.SLUMBER_CYC(2000)) uut (.clk(clk), .rst(rst),
      .rx_burst(rx_burst), .rx_align_seen(rx_align_seen),
      .spd_negotiated(spd_negotiated), .pm_partial_go(pm_partial_go),
      .pm_slumber_go(pm_slumber_go), .dev_wake_req(dev_wake_req),
      .id_addr(id_addr), .serial_num(serial_num),
      .tx_burst_reg(tx_burst_reg), .tx_common_mode_reg(tx_common_mode_reg),
      .tx_align_reg(tx_align_reg), .align_rate_reg(align_rate_reg),
      .phy_ready_reg(phy_ready_reg), .pll_on_reg(pll_on_reg),
      .in_partial_reg(in_partial_reg), .in_slumber_reg(in_slumber_reg),
      .link_accept_reg(link_accept_reg), .loss_reg(loss_reg),
      .id_data_reg(id_data_reg));

   sop_host_model host (.clk(clk), .send_reset(send_reset),
      .send_wake(send_wake), .tx_align_reg(tx_align_reg),
      .rx_burst(rx_burst), .rx_align_seen(rx_align_seen));

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Lines never sit at common mode while a burst is sent
   always @(negedge clk) begin
      if (!rst && tx_burst_reg === 1'b1)
         chk(16'(tx_common_mode_reg), 16'h0);
      if (loss_reg === 1'b1)
         loss_cnt++;
      if (tx_align_reg === 1'b1)
         align_cnt++;
   end

   task host_send(input logic is_reset);
      @(posedge clk);
      send_reset <= is_reset;
      send_wake <= !is_reset;
      @(posedge clk);
      send_reset <= 1'b0;
      send_wake <= 1'b0;
   endtask

   // Measures one idle gap of the device, then waits for it to go quiet
   task wait_tx(input int gap);
      int n, t;
      t = 0;
      while (tx_burst_reg !== 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      while (tx_burst_reg === 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      n = 0;
      while (tx_burst_reg !== 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
         n++;
      end
      chk(16'(n), 16'(gap));
      n = 0;
      while (n < 60 && t < 3000) begin
         @(negedge clk);
         t++;
         n = (tx_burst_reg === 1'b1) ? 0 : n + 1;
      end
      chk(16'(t < 3000), 16'h1);
   endtask

   task wait_ready(input int lim);
      int n;
      n = 0;
      while (phy_ready_reg !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(16'(phy_ready_reg), 16'h1);
      chk(16'(link_accept_reg), 16'h1);
      chk(16'(align_rate_reg), 16'h2);
      chk(16'(align_cnt > 0), 16'h1);
      align_cnt = 0;
   endtask

   task rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      id_addr <= a;
      @(posedge clk);
      @(negedge clk);
      chk(id_data_reg, exp);
   endtask

   task t_ident;
      rd(8'h2f, 16'h8008);
      rd(8'h3b, 16'h0108);
      for (int i = 65; i <= 68; i++) begin
         rd(8'(i), 16'h0078);
      end
      for (int i = 0; i < 10; i++) begin
         rd(8'(10 + i), serial_num[159-16*i -: 16]);
      end
      rd(8'h30, 16'h0000);
      $display("identify words done");
   endtask

   task t_power_on;
      chk(16'(tx_common_mode_reg), 16'h1);
      chk(16'(phy_ready_reg), 16'h0);
      host_send(1'b1);
      wait_tx(SECOND_SPACING_CYC);
      host_send(1'b0);
      wait_ready(400);
      chk(16'(pll_on_reg), 16'h1);
      $display("power-on sequence done");
   endtask

   task t_partial;
      @(posedge clk);
      spd_negotiated <= 2'h1;
      pm_partial_go <= 1'b1;
      @(posedge clk) pm_partial_go <= 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(in_partial_reg), 16'h1);
      chk(16'(link_accept_reg), 16'h0);
      chk(16'(tx_common_mode_reg), 16'h1);
      host_send(1'b0);
      wait_ready(PARTIAL_EXIT_CYC);
      chk(16'(in_partial_reg), 16'h0);
      $display("partial resume done");
   endtask

   task t_slumber;
      @(posedge clk);
      pm_slumber_go <= 1'b1;
      @(posedge clk) pm_slumber_go <= 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(in_slumber_reg), 16'h1);
      chk(16'(pll_on_reg), 16'h0);
      chk(16'(phy_ready_reg), 16'h0);
      @(posedge clk) dev_wake_req <= 1'b1;
      @(posedge clk) dev_wake_req <= 1'b0;
      wait_tx(FIRST_SPACING_CYC);
      host_send(1'b0);
      wait_ready(2000);
      chk(16'(loss_cnt), 16'h0);
      $display("slumber device wake done");
   endtask

   task t_loss;
      int n;
      host_send(1'b1);
      n = 0;
      while (loss_cnt == 0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(16'(loss_cnt), 16'h1);
      chk(16'(phy_ready_reg), 16'h0);
      $display("signal loss done");
   endtask

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_ident();
      t_power_on();
      t_partial();
      t_slumber();
      t_loss();
      stop_test();
   end

   // Watchdog well beyond the few thousand cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      stop_test();
   end
endmodule
